// >>> rtl/aasd_datapath.sv
// Notes on behaviour
// - swap writes work register to memory, loads old byte; flags untouched
// - save stores flags and work register at stack top, then pointer plus 2
// - restore drops pointer by 2 first, then reloads flags and work register
// - add immediate into work register, updating all four flags
// - add memory byte, result to work register or memory, all flags
// - add with carry in of memory byte, result to either place, all flags
// - add carry alone to work register or memory byte, in place, all flags
// - subtract immediate via two's complement into work register, all flags
// - subtract work-minus-memory or memory-minus-work, result to minuend place
// - work register minus memory minus carry into work register, all flags
// - memory minus work register minus carry back into memory, all flags
// - subtract carry alone from work register or memory, in place, all flags
// - increment memory byte in place, updating all four flags
// - decrement memory byte in place, updating all four flags
// - clear writes zero to memory byte, flags untouched
// - work register is eight bits, bit 7 most significant
`timescale 1ns/1ps
`default_nettype none
`include "aasd_defs.svh"

module aasd_datapath
  import aasd_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  // sequencer side
  input wire logic op_valid_i,
  input wire aasd_op_e op_code_i,
  input wire logic [7:0] op_addr_i,
  input wire logic [7:0] op_imm_i,
  output logic op_ready_o,
  output logic op_done_o,
  // stack pointer load
  input wire logic sp_load_i,
  input wire logic [7:0] sp_load_val_i,
  // state shown outward
  output logic [7:0] work_register_o,
  output logic [3:0] flags_o,
  output logic [7:0] stack_top_pointer_o,
  // data memory, combinational read of mem_addr_o
  output logic [7:0] mem_addr_o,
  output logic [7:0] mem_wdata_o,
  output logic mem_we_o,
  input wire logic [7:0] mem_rdata_i
);

  // ==========================================================
  // decode helpers
  function automatic logic dest_is_mem(input aasd_op_e op);
    case (op)
      AASD_OP_ADD_MA, AASD_OP_ADDC_MA, AASD_OP_ADDC_M, AASD_OP_SUB_MA,
      AASD_OP_SUBC_MA, AASD_OP_SUBC_M, AASD_OP_INC_M, AASD_OP_DEC_M: dest_is_mem = 1'b1;
      default: dest_is_mem = 1'b0;
    endcase
  endfunction

  function automatic logic is_arith(input aasd_op_e op);
    case (op)
      AASD_OP_NOP, AASD_OP_XCH, AASD_OP_PUSH, AASD_OP_POP,
      AASD_OP_CLEAR_M: is_arith = 1'b0;
      default: is_arith = 1'b1;
    endcase
  endfunction

  // ==========================================================
  // state
  aasd_state_e state_q, state_d;
  aasd_op_e op_q;
  logic [7:0] work_q;
  logic [3:0] flags_q;
  logic [7:0] addr_q;
  logic [7:0] imm_q;
  logic [7:0] wdata_q;
  logic we_q;
  logic done_q;
  logic [7:0] pop_work_q;
  logic [7:0] sp;

  wire logic accept = (state_q == AASD_ST_IDLE) && op_valid_i && (op_code_i != AASD_OP_NOP);
  wire logic sp_up = (state_q == AASD_ST_PUSH_HI);
  wire logic sp_down = accept && (op_code_i == AASD_OP_POP);

  aasd_stack_ptr u_sp (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .load_i(sp_load_i),
    .load_val_i(sp_load_val_i),
    .step_up_i(sp_up),
    .step_down_i(sp_down),
    .sp_o(sp)
  );

  // ==========================================================
  // operand selection
  wire logic carry = flags_q[`AASD_FLAG_C];
  wire logic mem_first = dest_is_mem(op_q);
  wire logic op_sub = (op_q == AASD_OP_SUB_AI) || (op_q == AASD_OP_SUB_AM) ||
                      (op_q == AASD_OP_SUB_MA) || (op_q == AASD_OP_SUBC_AM) ||
                      (op_q == AASD_OP_SUBC_MA) || (op_q == AASD_OP_SUBC_A) ||
                      (op_q == AASD_OP_SUBC_M) || (op_q == AASD_OP_DEC_M);
  wire logic op_cy_add = (op_q == AASD_OP_ADDC_AM) || (op_q == AASD_OP_ADDC_MA) ||
                         (op_q == AASD_OP_ADDC_A) || (op_q == AASD_OP_ADDC_M);
  wire logic op_cy_sub = (op_q == AASD_OP_SUBC_AM) || (op_q == AASD_OP_SUBC_MA) ||
                         (op_q == AASD_OP_SUBC_A) || (op_q == AASD_OP_SUBC_M);
  wire logic carry_only = (op_q == AASD_OP_ADDC_A) || (op_q == AASD_OP_ADDC_M) ||
                          (op_q == AASD_OP_SUBC_A) || (op_q == AASD_OP_SUBC_M);
  wire logic imm_form = (op_q == AASD_OP_ADD_AI) || (op_q == AASD_OP_SUB_AI);
  wire logic unit_form = (op_q == AASD_OP_INC_M) || (op_q == AASD_OP_DEC_M);

  // memory-destination forms take the memory byte as first operand
  wire logic [7:0] alu_a = mem_first ? mem_rdata_i : work_q;
  wire logic [7:0] alu_b = imm_form ? imm_q :
                           carry_only ? `AASD_ZERO :
                           unit_form ? `AASD_ONE :
                           mem_first ? work_q : mem_rdata_i;
  // subtraction without borrow feeds a carry in of one
  wire logic alu_cin = op_cy_add ? carry :
                       op_cy_sub ? ~carry :
                       op_sub;

  logic [7:0] alu_sum;
  logic alu_z, alu_c, alu_ac, alu_ov;

  aasd_adder u_add (
    .a_i(alu_a),
    .b_i(alu_b),
    .cin_i(alu_cin),
    .sub_i(op_sub),
    .sum_o(alu_sum),
    .zero_o(alu_z),
    .carry_o(alu_c),
    .half_o(alu_ac),
    .ovf_o(alu_ov)
  );

  wire logic [3:0] alu_flags = {alu_ov, alu_ac, alu_c, alu_z};
  wire logic in_exec = (state_q == AASD_ST_EXEC);
  wire logic exec_arith = in_exec && is_arith(op_q);

  // ==========================================================
  // next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      AASD_ST_IDLE: begin
        if (accept) begin
          case (op_code_i)
            AASD_OP_CLEAR_M, AASD_OP_PUSH: state_d = AASD_ST_WB;
            AASD_OP_POP: state_d = AASD_ST_POP_LO;
            default: state_d = AASD_ST_EXEC;
          endcase
        end
      end
      AASD_ST_EXEC: begin
        if ((op_q == AASD_OP_XCH) || dest_is_mem(op_q)) begin
          state_d = AASD_ST_WB;
        end else begin
          state_d = AASD_ST_IDLE;
        end
      end
      AASD_ST_WB: begin
        if (op_q == AASD_OP_PUSH) begin
          state_d = AASD_ST_PUSH_HI;
        end else begin
          state_d = AASD_ST_IDLE;
        end
      end
      AASD_ST_PUSH_HI: state_d = AASD_ST_IDLE;
      AASD_ST_POP_LO: state_d = AASD_ST_POP_HI;
      AASD_ST_POP_HI: state_d = AASD_ST_IDLE;
      default: state_d = AASD_ST_IDLE;
    endcase
  end

  // ==========================================================
  // control and memory port registers
  wire logic exec_to_wb = in_exec && (state_d == AASD_ST_WB);
  wire logic op_finish = (state_q != AASD_ST_IDLE) && (state_d == AASD_ST_IDLE);

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= AASD_ST_IDLE;
      op_q <= AASD_OP_NOP;
      imm_q <= `AASD_ZERO;
      done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      done_q <= op_finish;
      if (accept) begin
        op_q <= op_code_i;
        imm_q <= op_imm_i;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      addr_q <= `AASD_ZERO;
    end else if (accept) begin
      case (op_code_i)
        AASD_OP_PUSH: addr_q <= sp;
        AASD_OP_POP: addr_q <= sp - `AASD_SP_STEP;
        default: addr_q <= op_addr_i;
      endcase
    end else if ((state_q == AASD_ST_WB) || (state_q == AASD_ST_POP_LO)) begin
      addr_q <= addr_q + `AASD_ONE;
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      we_q <= 1'b0;
      wdata_q <= `AASD_ZERO;
    end else begin
      we_q <= 1'b0;
      if (accept && (op_code_i == AASD_OP_CLEAR_M)) begin
        we_q <= 1'b1;
        wdata_q <= `AASD_ZERO;
      end else if (accept && (op_code_i == AASD_OP_PUSH)) begin
        we_q <= 1'b1;
        wdata_q <= work_q;
      end else if ((state_q == AASD_ST_WB) && (op_q == AASD_OP_PUSH)) begin
        we_q <= 1'b1;
        wdata_q <= {4'h0, flags_q};
      end else if (exec_to_wb) begin
        we_q <= 1'b1;
        wdata_q <= (op_q == AASD_OP_XCH) ? work_q : alu_sum;
      end
    end
  end

  // ==========================================================
  // work register and flags
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      work_q <= `AASD_WORK_RST;
      flags_q <= `AASD_FLAGS_RST;
      pop_work_q <= `AASD_ZERO;
    end else begin
      if (in_exec && (op_q == AASD_OP_XCH)) begin
        work_q <= mem_rdata_i;
      end else if (exec_arith && !mem_first) begin
        work_q <= alu_sum;
      end else if (state_q == AASD_ST_POP_HI) begin
        work_q <= pop_work_q;
      end
      if (exec_arith) begin
        flags_q <= alu_flags;
      end else if (state_q == AASD_ST_POP_HI) begin
        flags_q <= mem_rdata_i[3:0];
      end
      if (state_q == AASD_ST_POP_LO) begin
        pop_work_q <= mem_rdata_i;
      end
    end
  end

  // ==========================================================
  // outputs
  assign op_ready_o = (state_q == AASD_ST_IDLE);
  assign op_done_o = done_q;
  assign work_register_o = work_q;
  assign flags_o = flags_q;
  assign stack_top_pointer_o = sp;
  assign mem_addr_o = addr_q;
  assign mem_wdata_o = wdata_q;
  assign mem_we_o = we_q;

endmodule

`default_nettype wire

// >>> rtl/aasd_defs.svh
`ifndef AASD_DEFS_SVH
`define AASD_DEFS_SVH

// ==========================================================
// widths
`define AASD_DATA_W 8
`define AASD_ADDR_W 8
`define AASD_FLAG_W 4

// ==========================================================
// flag byte bit positions
`define AASD_FLAG_Z 0
`define AASD_FLAG_C 1
`define AASD_FLAG_AC 2
`define AASD_FLAG_OV 3

// ==========================================================
// reset values and constants
`define AASD_WORK_RST 8'h00
`define AASD_FLAGS_RST 4'h0
`define AASD_SP_RST 8'h00
`define AASD_SP_STEP 8'h02
`define AASD_ONE 8'h01
`define AASD_ZERO 8'h00

`endif

// >>> rtl/aasd_pkg.sv
package aasd_pkg;

  // operations issued by the sequencer
  typedef enum logic [4:0] {
    AASD_OP_NOP,
    AASD_OP_XCH,
    AASD_OP_PUSH,
    AASD_OP_POP,
    AASD_OP_ADD_AI,
    AASD_OP_ADD_AM,
    AASD_OP_ADD_MA,
    AASD_OP_ADDC_AM,
    AASD_OP_ADDC_MA,
    AASD_OP_ADDC_A,
    AASD_OP_ADDC_M,
    AASD_OP_SUB_AI,
    AASD_OP_SUB_AM,
    AASD_OP_SUB_MA,
    AASD_OP_SUBC_AM,
    AASD_OP_SUBC_MA,
    AASD_OP_SUBC_A,
    AASD_OP_SUBC_M,
    AASD_OP_INC_M,
    AASD_OP_DEC_M,
    AASD_OP_CLEAR_M
  } aasd_op_e;

  typedef enum {
    AASD_ST_IDLE,
    AASD_ST_EXEC,
    AASD_ST_WB,
    AASD_ST_PUSH_HI,
    AASD_ST_POP_LO,
    AASD_ST_POP_HI
  } aasd_state_e;

endpackage

// >>> rtl/aasd_adder.sv
`timescale 1ns/1ps
`default_nettype none
`include "aasd_defs.svh"

module aasd_adder (
  input wire logic [7:0] a_i,
  input wire logic [7:0] b_i,
  input wire logic cin_i,
  input wire logic sub_i,
  output logic [7:0] sum_o,
  output logic zero_o,
  output logic carry_o,
  output logic half_o,
  output logic ovf_o
);

  // ==========================================================
  // two's complement add; borrow flags are inverted carries
  wire logic [7:0] b_eff = sub_i ? ~b_i : b_i;
  wire logic [8:0] full_sum = {1'b0, a_i} + {1'b0, b_eff} + {8'h00, cin_i};
  wire logic [4:0] low_sum = {1'b0, a_i[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin_i};

  assign sum_o = full_sum[7:0];
  assign zero_o = (full_sum[7:0] == `AASD_ZERO);
  assign carry_o = full_sum[8] ^ sub_i;
  assign half_o = low_sum[4] ^ sub_i;
  assign ovf_o = (a_i[7] == b_eff[7]) && (full_sum[7] != a_i[7]);

endmodule

`default_nettype wire

// >>> rtl/aasd_stack_ptr.sv
`timescale 1ns/1ps
`default_nettype none
`include "aasd_defs.svh"

module aasd_stack_ptr (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic load_i,
  input wire logic [7:0] load_val_i,
  input wire logic step_up_i,
  input wire logic step_down_i,
  output logic [7:0] sp_o
);

  logic [7:0] sp_q;
  logic [7:0] sp_d;

  // ==========================================================
  // pointer update; load has priority over steps
  assign sp_d = load_i ? load_val_i :
                step_up_i ? sp_q + `AASD_SP_STEP :
                step_down_i ? sp_q - `AASD_SP_STEP :
                sp_q;

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sp_q <= `AASD_SP_RST;
    end else begin
      sp_q <= sp_d;
    end
  end

  assign sp_o = sp_q;

endmodule

`default_nettype wire

// >>> verif/aasd_datapath_props.sv
`timescale 1ns/1ps
`default_nettype none
module aasd_datapath_props
  import aasd_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic op_valid_i,
  input wire aasd_op_e op_code_i,
  input wire logic [7:0] op_addr_i,
  input wire logic [7:0] op_imm_i,
  input wire logic op_ready_o,
  input wire logic op_done_o,
  input wire logic [7:0] work_register_o,
  input wire logic [3:0] flags_o,
  input wire logic [7:0] stack_top_pointer_o,
  input wire logic [7:0] mem_addr_o,
  input wire logic [7:0] mem_wdata_o,
  input wire logic mem_we_o,
  input wire logic [7:0] mem_rdata_i
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  wire logic tk;
  assign tk = op_valid_i && op_ready_o && op_code_i != AASD_OP_NOP;
  // ==========================================
  // assertions
  a_swap_flags_keep: assert property (tk && op_code_i == AASD_OP_XCH |=> $stable(flags_o) [*3])
    else $error("flags moved during swap");
  a_swap_data_cross: assert property (tk && op_code_i == AASD_OP_XCH |=> ##1 mem_we_o &&
    work_register_o == $past(mem_rdata_i) && mem_wdata_o == $past(work_register_o, 2))
    else $error("swap data wrong");
  a_save_layout: assert property (tk && op_code_i == AASD_OP_PUSH |=> mem_we_o &&
    mem_addr_o == $past(stack_top_pointer_o) && mem_wdata_o == $past(work_register_o)
    ##1 mem_we_o && mem_addr_o == 8'($past(stack_top_pointer_o, 2) + 8'h01)
    && mem_wdata_o == {4'h0, flags_o})
    else $error("save layout wrong");
  a_save_step: assert property (tk && op_code_i == AASD_OP_PUSH |-> ##3 op_done_o &&
    stack_top_pointer_o == 8'($past(stack_top_pointer_o, 3) + 8'h02))
    else $error("save pointer step wrong");
  a_restore_drop: assert property (tk && op_code_i == AASD_OP_POP |=>
    stack_top_pointer_o == 8'($past(stack_top_pointer_o) - 8'h02)
    && mem_addr_o == stack_top_pointer_o)
    else $error("restore pointer drop wrong");
  a_restore_load: assert property (tk && op_code_i == AASD_OP_POP |-> ##3
    work_register_o == $past(mem_rdata_i, 2) && flags_o == 4'($past(mem_rdata_i)))
    else $error("restore load wrong");
  a_clear_zero: assert property (tk && op_code_i == AASD_OP_CLEAR_M |=> mem_we_o &&
    mem_wdata_o == 8'h00 && mem_addr_o == $past(op_addr_i)
    ##1 op_done_o && flags_o == $past(flags_o, 2))
    else $error("clear wrong");
  a_inc_byte: assert property (tk && op_code_i == AASD_OP_INC_M |=> ##1 mem_we_o &&
    mem_wdata_o == 8'($past(mem_rdata_i) + 8'h01))
    else $error("increment wrong");
  a_dec_byte: assert property (tk && op_code_i == AASD_OP_DEC_M |=> ##1 mem_we_o &&
    mem_wdata_o == 8'($past(mem_rdata_i) - 8'h01))
    else $error("decrement wrong");
  a_imm_add: assert property (tk && op_code_i == AASD_OP_ADD_AI |-> ##2 op_done_o &&
    work_register_o == 8'($past(work_register_o, 2) + $past(op_imm_i, 2)))
    else $error("immediate add wrong");
  c_save: cover property (tk && op_code_i == AASD_OP_PUSH);
  c_restore: cover property (tk && op_code_i == AASD_OP_POP);
  c_carry_set: cover property (op_done_o && flags_o[1]);
endmodule
bind aasd_datapath aasd_datapath_props u_props (
  .clk_sys_i, .arst_n_i, .op_valid_i, .op_code_i, .op_addr_i, .op_imm_i,
  .op_ready_o, .op_done_o, .work_register_o, .flags_o, .stack_top_pointer_o,
  .mem_addr_o, .mem_wdata_o, .mem_we_o, .mem_rdata_i
);
`default_nettype wire

// >>> verif/aasd_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module aasd_mem_model (
  input wire logic clk_sys_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic we_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem_q [256];
  assign rdata_o = mem_q[addr_i];
  always @(posedge clk_sys_i) begin
    if (we_i) mem_q[addr_i] <= wdata_i;
  end
endmodule
`default_nettype wire

// >>> verif/acc_arith_stack_datapath_tb.sv
`timescale 1ns/1ps
`default_nettype none
module acc_arith_stack_datapath_tb;
  import aasd_pkg::*;
  logic clk_sys_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic op_valid_i = 1'b0;
  logic sp_load_i = 1'b0;
  aasd_op_e op_code_i = AASD_OP_NOP;
  logic [7:0] op_addr_i = 8'h00;
  logic [7:0] op_imm_i = 8'h00;
  logic [7:0] sp_load_val_i = 8'h00;
  logic op_ready_o, op_done_o, mem_we_o;
  logic [7:0] work_register_o, stack_top_pointer_o, mem_addr_o, mem_wdata_o, mem_rdata_i;
  logic [3:0] flags_o;
  logic [7:0] mm [256];
  logic [7:0] wk, spm;
  logic [3:0] fl;
  int mismatches = 0;
  int cmp_count = 0;
  initial forever #20 clk_sys_i = ~clk_sys_i;
  aasd_datapath uut (.clk_sys_i, .arst_n_i, .op_valid_i, .op_code_i, .op_addr_i, .op_imm_i,
    .op_ready_o, .op_done_o, .sp_load_i, .sp_load_val_i, .work_register_o, .flags_o,
    .stack_top_pointer_o, .mem_addr_o, .mem_wdata_o, .mem_we_o, .mem_rdata_i);
  aasd_mem_model mem (.clk_sys_i, .addr_i(mem_addr_o), .wdata_i(mem_wdata_o),
    .we_i(mem_we_o), .rdata_o(mem_rdata_i));
  // ==========================================
  // reference and checks
  function automatic logic [11:0] alu(logic [7:0] a, logic [7:0] b, logic ci, logic s);
    logic [8:0] r;
    logic [4:0] n;
    logic v;
    if (s) begin
      r = {1'b0, a} - b - ci;
      n = {1'b0, a[3:0]} - b[3:0] - ci;
      v = (a[7] != b[7]) && (r[7] != a[7]);
    end else begin
      r = a + b + ci;
      n = a[3:0] + b[3:0] + ci;
      v = (a[7] == b[7]) && (r[7] != a[7]);
    end
    return {v, n[4], r[8], r[7:0] == 8'h00, r[7:0]};
  endfunction
  task automatic report_and_stop;
    if (mismatches == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cmp_all;
    chk("work", work_register_o, wk);
    chk("flags", {4'h0, flags_o}, {4'h0, fl});
    chk("pointer", stack_top_pointer_o, spm);
    for (int i = 0; i < 256; i++) chk("memory", mem.mem_q[i], mm[i]);
  endtask
  task automatic run(aasd_op_e op, logic [7:0] ad, logic [7:0] im);
    logic [7:0] m, a, b;
    logic c, s, tom;
    logic [11:0] x;
    int n;
    m = mm[ad];
    a = wk;
    b = m;
    c = 1'b0;
    s = 1'b0;
    tom = 1'b0;
    case (op)
      AASD_OP_ADD_AI: b = im;
      AASD_OP_ADD_MA: tom = 1'b1;
      AASD_OP_ADDC_AM: c = fl[1];
      AASD_OP_ADDC_MA: {c, tom} = {fl[1], 1'b1};
      AASD_OP_ADDC_A: {b, c} = {8'h00, fl[1]};
      AASD_OP_ADDC_M: {a, b, c, tom} = {m, 8'h00, fl[1], 1'b1};
      AASD_OP_SUB_AI: {b, s} = {im, 1'b1};
      AASD_OP_SUB_AM: s = 1'b1;
      AASD_OP_SUB_MA: {a, b, s, tom} = {m, wk, 2'b11};
      AASD_OP_SUBC_AM: {c, s} = {fl[1], 1'b1};
      AASD_OP_SUBC_MA: {a, b, c, s, tom} = {m, wk, fl[1], 2'b11};
      AASD_OP_SUBC_A: {b, c, s} = {8'h00, fl[1], 1'b1};
      AASD_OP_SUBC_M: {a, b, c, s, tom} = {m, 8'h00, fl[1], 2'b11};
      AASD_OP_INC_M: {a, b, tom} = {m, 8'h01, 1'b1};
      AASD_OP_DEC_M: {a, b, s, tom} = {m, 8'h01, 2'b11};
      default: ;
    endcase
    x = alu(a, b, c, s);
    @(posedge clk_sys_i);
    #1;
    op_valid_i = 1'b1;
    op_code_i = op;
    op_addr_i = ad;
    op_imm_i = im;
    @(posedge clk_sys_i);
    #1;
    // junk request held while busy must be ignored
    op_code_i = AASD_OP_CLEAR_M;
    op_addr_i = ~ad;
    for (n = 0; n < 8 && op_done_o !== 1'b1; n++) begin
      @(posedge clk_sys_i);
      #1;
    end
    op_valid_i = 1'b0;
    if (n == 8) begin
      mismatches++;
      report_and_stop();
    end
    case (op)
      AASD_OP_XCH: {mm[ad], wk} = {wk, m};
      AASD_OP_PUSH: begin
        mm[spm] = wk;
        mm[spm + 8'h01] = {4'h0, fl};
        spm = spm + 8'h02;
      end
      AASD_OP_POP: begin
        spm = spm - 8'h02;
        wk = mm[spm];
        fl = mm[spm + 8'h01][3:0];
      end
      AASD_OP_CLEAR_M: mm[ad] = 8'h00;
      default: begin
        fl = x[11:8];
        if (tom) mm[ad] = x[7:0];
        else wk = x[7:0];
      end
    endcase
    cmp_all();
  endtask
  // ==========================================
  // main sequence
  initial begin
    void'($urandom(32'h0f2d_e971));
    for (int i = 0; i < 256; i++) begin
      mm[i] = 8'($urandom);
      mem.mem_q[i] = mm[i];
    end
    mm[0] = 8'h7f;
    mem.mem_q[0] = 8'h7f;
    {wk, fl, spm} = 20'h0_0000;
    repeat (6) @(posedge clk_sys_i);
    #1;
    arst_n_i = 1'b1;
    chk("ready", {7'h00, op_ready_o}, 8'h01);
    cmp_all();
    sp_load_val_i = 8'hfe;
    sp_load_i = 1'b1;
    @(posedge clk_sys_i);
    #1;
    sp_load_i = 1'b0;
    spm = 8'hfe;
    run(AASD_OP_PUSH, 8'h00, 8'h00);
    run(AASD_OP_XCH, 8'h00, 8'h00);
    run(AASD_OP_ADD_AI, 8'h00, 8'h01);
    run(AASD_OP_ADD_AI, 8'h00, 8'h80);
    run(AASD_OP_SUBC_A, 8'h00, 8'h00);
    run(AASD_OP_SUB_AI, 8'h00, 8'hff);
    run(AASD_OP_INC_M, 8'h00, 8'h00);
    run(AASD_OP_DEC_M, 8'h00, 8'h00);
    run(AASD_OP_CLEAR_M, 8'h00, 8'h00);
    run(AASD_OP_POP, 8'h00, 8'h00);
    repeat (300) run(aasd_op_e'($urandom_range(20, 1)), 8'($urandom), 8'($urandom));
    arst_n_i = 1'b0;
    repeat (2) @(posedge clk_sys_i);
    #1;
    arst_n_i = 1'b1;
    {wk, fl, spm} = 20'h0_0000;
    cmp_all();
    repeat (30) run(aasd_op_e'($urandom_range(20, 1)), 8'($urandom), 8'($urandom));
    report_and_stop();
  end
endmodule
`default_nettype wire
